// *** hw/ubd_pkg.sv ***
// Package of descriptor constants for the BOS and companion generator
package ubd_pkg;

  // ****************************************
  // Fixed descriptor bytes
  // ****************************************
  localparam logic [7:0] UBD_EPC_LEN = 8'h06; // Companion length
  localparam logic [7:0] UBD_EPC_TYPE = 8'h30; // Companion type
  localparam logic [7:0] UBD_EPC_BURST = 8'h00; // One packet per burst
  localparam logic [7:0] UBD_EPC_BURST_MAX = 8'h0F; // Largest legal burst
  localparam logic [7:0] UBD_EPC_ATTR = 8'h00; // Reserved attributes
  localparam logic [15:0] UBD_EPC_BPI = 16'h0004; // Bytes per interval
  localparam logic [7:0] UBD_BOS_LEN = 8'h05; // BOS header length
  localparam logic [7:0] UBD_BOS_TYPE = 8'h0F; // BOS header type
  localparam logic [15:0] UBD_BOS_TOTAL_RST = 16'h0016; // Default total
  localparam logic [7:0] UBD_BOS_NCAPS_RST = 8'h02; // Default cap count
  localparam logic [7:0] UBD_EXT_LEN = 8'h07; // Extension length
  localparam logic [7:0] UBD_EXT_TYPE = 8'h10; // Device capability type
  localparam logic [7:0] UBD_EXT_CAP = 8'h02; // Extension capability
  localparam logic [31:0] UBD_EXT_ATTR_RST = 32'h0000_0006; // Default attr
  localparam logic [31:0] UBD_EXT_ATTR_MASK = 32'h0000_FF1E; // Defined bits

  // ****************************************
  // Field positions and sizes
  // ****************************************
  localparam int UBD_ATTR_LPM = 1; // Link power management bit
  localparam int UBD_ATTR_BESL = 2; // BESL supported bit
  localparam int UBD_EPC_SIZE = 6; // Companion byte count
  localparam int UBD_BOS_SIZE = 5; // BOS header byte count
  localparam int UBD_EXT_SIZE = 7; // Extension byte count

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] UBD_OFF_CTRL = 12'h000; // Load control
  localparam logic [11:0] UBD_OFF_BOS = 12'h004; // BOS total and count
  localparam logic [11:0] UBD_OFF_EXT = 12'h008; // Extension attributes
  localparam logic [11:0] UBD_OFF_STAT = 12'h00C; // Status
  localparam logic [11:0] UBD_OFF_RDSEL = 12'h010; // Read-back select
  localparam logic [11:0] UBD_OFF_RDDAT = 12'h014; // Read-back byte

  // Descriptor selector for byte fetches
  typedef enum logic [1:0] {
    UBD_SEL_EPC = 2'b00,
    UBD_SEL_BOS = 2'b01,
    UBD_SEL_EXT = 2'b11
  } ubd_sel_t;

endpackage : ubd_pkg

// *** hw/ubd_fetch_if.sv ***
// Interface carrying byte fetches from the engine to the descriptor store
`timescale 1ns/10ps
`default_nettype none
interface ubd_fetch_if;
  import ubd_pkg::*;
  ubd_sel_t sel; // Descriptor chosen
  logic [2:0] idx; // Byte offset within it
  logic [7:0] data; // Byte returned
  logic valid; // Offset lies inside descriptor
  modport engine (output sel, output idx, input data, input valid);
  modport store (input sel, input idx, output data, output valid);
endinterface : ubd_fetch_if
`default_nettype wire

// *** hw/ubd_store.sv ***
// Descriptor byte store: merges fixed bytes with loaded fields
`timescale 1ns/10ps
`default_nettype none
module ubd_store
  import ubd_pkg::*;
(
  ubd_fetch_if.store fetch, // Byte fetch port
  input wire logic [15:0] bos_total, // Loaded BOS total length
  input wire logic [7:0] bos_ncaps, // Loaded capability count
  input wire logic [31:0] ext_attr // Loaded extension attributes
);

  // ****************************************
  // Byte selection, multi-byte fields low byte first
  // ****************************************
  always_comb begin
    fetch.data = 8'h00;
    fetch.valid = 1'b0;
    case (fetch.sel)
      UBD_SEL_EPC: begin // All fixed, nothing loaded (see RULE5)
        fetch.valid = (int'(fetch.idx) < UBD_EPC_SIZE);
        case (fetch.idx)
          3'd0: fetch.data = UBD_EPC_LEN; // see RULE1
          3'd1: fetch.data = UBD_EPC_TYPE; // see RULE1
          3'd2: fetch.data = UBD_EPC_BURST; // see RULE2
          3'd3: fetch.data = UBD_EPC_ATTR; // see RULE3
          3'd4: fetch.data = UBD_EPC_BPI[7:0]; // see RULE4 and RULE15
          3'd5: fetch.data = UBD_EPC_BPI[15:8]; // see RULE4
          default: fetch.data = 8'h00;
        endcase
      end
      UBD_SEL_BOS: begin
        fetch.valid = (int'(fetch.idx) < UBD_BOS_SIZE);
        case (fetch.idx)
          3'd0: fetch.data = UBD_BOS_LEN; // Stored value ignored, see RULE8
          3'd1: fetch.data = UBD_BOS_TYPE; // see RULE8
          3'd2: fetch.data = bos_total[7:0]; // see RULE6 and RULE15
          3'd3: fetch.data = bos_total[15:8]; // see RULE6
          3'd4: fetch.data = bos_ncaps; // see RULE7
          default: fetch.data = 8'h00;
        endcase
      end
      UBD_SEL_EXT: begin
        fetch.valid = (int'(fetch.idx) < UBD_EXT_SIZE);
        case (fetch.idx)
          3'd0: fetch.data = UBD_EXT_LEN; // see RULE9
          3'd1: fetch.data = UBD_EXT_TYPE; // see RULE9
          3'd2: fetch.data = UBD_EXT_CAP; // see RULE9
          3'd3: fetch.data = ext_attr[7:0]; // see RULE10 and RULE15
          3'd4: fetch.data = ext_attr[15:8]; // BESL fields, see RULE11
          3'd5: fetch.data = ext_attr[23:16];
          3'd6: fetch.data = ext_attr[31:24];
          default: fetch.data = 8'h00;
        endcase
      end
      default: begin // Unused selector returns nothing
        fetch.data = 8'h00;
        fetch.valid = 1'b0;
      end
    endcase
  end

endmodule : ubd_store
`default_nettype wire

// *** hw/ubd_gen.sv ***
// Top of the BOS and interrupt companion descriptor generator
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RULE1) Companion length six, type 30h
// (RULE2) Companion burst reads zero, one packet
// (RULE3) Companion attributes byte always zero
// (RULE4) Companion bytes per interval reads four
// (RULE5) Companion built only from fixed values
// (RULE6) BOS total loaded, else defaults 22
// (RULE7) Capability count loaded, else defaults two
// (RULE8) BOS length and type always 05h/0Fh
// (RULE9) Extension length, type, capability fixed
// (RULE10) Extension attributes loaded, default 0006h
// (RULE11) BESL values in 15:12, 11:8
// (RULE12) Memory sets BESL bit only with LPM
// (RULE13) Memory keeps LPM bit set
// (RULE14) LPM bit equals memory capability flag
// (RULE15) Multi-byte fields sent low byte first
module ubd_gen
  import ubd_pkg::*;
(
  input wire logic pclk, // Clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic nvm_link_power_mgmt_flag, // Memory LPM capable flag
  input wire logic [1:0] req_sel, // Engine descriptor choice
  input wire logic [2:0] req_idx, // Engine byte offset
  input wire logic req_valid, // Engine byte request
  output logic [7:0] rsp_data, // Byte answered
  output logic rsp_valid, // Answer strobe
  output logic rsp_last // Answer is descriptor's last byte
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic loaded; // Memory image accepted
    logic [15:0] bos_total; // BOS total length
    logic [7:0] bos_ncaps; // Capability count
    logic [31:0] ext_attr; // Extension attributes
    logic [31:0] rdata; // Registered read data
    logic slverr; // Registered error
    logic ready; // Access-phase answer
    logic [1:0] rd_sel; // Read-back selector
    logic [2:0] rd_idx; // Read-back offset
    logic [7:0] rsp_data; // Engine answer byte
    logic rsp_valid; // Engine answer strobe
    logic rsp_last; // Engine last-byte flag
    logic cfg_warn; // Loaded image breaks attribute pairing
  } ubd_state_t;

  ubd_state_t st; // Current state
  ubd_state_t next_st; // Next state

  ubd_fetch_if eng_if (); // Engine side fetch
  ubd_fetch_if apb_if (); // Register read-back fetch

  // Two stores: engine and read-back may look at different bytes at once
  ubd_store u_store_eng (
    .fetch(eng_if.store),
    .bos_total(st.bos_total),
    .bos_ncaps(st.bos_ncaps),
    .ext_attr(st.ext_attr)
  );
  ubd_store u_store_apb (
    .fetch(apb_if.store),
    .bos_total(st.bos_total),
    .bos_ncaps(st.bos_ncaps),
    .ext_attr(st.ext_attr)
  );

  assign eng_if.sel = ubd_sel_t'(req_sel);
  assign eng_if.idx = req_idx;
  assign apb_if.sel = ubd_sel_t'(st.rd_sel);
  assign apb_if.idx = st.rd_idx;

  // ****************************************
  // Helpers
  // ****************************************
  // True when an attribute word breaks the LPM pairing expected of memory
  function automatic logic ubd_attr_bad(input logic [31:0] a,
                                        input logic flag);
    ubd_attr_bad = (a[UBD_ATTR_BESL] & ~a[UBD_ATTR_LPM]) // see RULE12
                 | ~a[UBD_ATTR_LPM] // see RULE13
                 | (a[UBD_ATTR_LPM] != flag); // see RULE14
  endfunction : ubd_attr_bad

  // Last offset of the chosen descriptor
  function automatic logic [2:0] ubd_last_idx(input logic [1:0] s);
    case (ubd_sel_t'(s))
      UBD_SEL_EPC: ubd_last_idx = 3'(UBD_EPC_SIZE - 1);
      UBD_SEL_BOS: ubd_last_idx = 3'(UBD_BOS_SIZE - 1);
      default: ubd_last_idx = 3'(UBD_EXT_SIZE - 1);
    endcase
  endfunction : ubd_last_idx

  logic wr_phase; // Setup done, write taken this access cycle
  logic rd_phase; // Setup cycle of a read

  assign wr_phase = psel & penable & pwrite & st.ready;
  assign rd_phase = psel & ~penable & ~pwrite;

  // ****************************************
  // Next-state logic
  // ****************************************
  // No wait cycle in any access: read data is prepared in setup, ready
  // rises in the access phase and the transfer ends there.
  always_comb begin
    next_st = st;
    next_st.ready = psel & ~penable;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_last = 1'b0;
    if (req_valid & eng_if.valid) begin // Serve engine byte
      next_st.rsp_data = eng_if.data;
      next_st.rsp_valid = 1'b1;
      next_st.rsp_last = (req_idx == ubd_last_idx(req_sel));
    end
    if (rd_phase) begin // Prepare read data
      next_st.slverr = 1'b0;
      case (paddr)
        UBD_OFF_CTRL: next_st.rdata = {31'h0000_0000, st.loaded};
        UBD_OFF_BOS: next_st.rdata = {8'h00, st.bos_ncaps, st.bos_total};
        UBD_OFF_EXT: next_st.rdata = st.ext_attr;
        UBD_OFF_STAT: next_st.rdata = {30'h0000_0000, st.cfg_warn,
                                       nvm_link_power_mgmt_flag};
        UBD_OFF_RDSEL: next_st.rdata = {27'h0000_0000, st.rd_sel,
                                        st.rd_idx};
        UBD_OFF_RDDAT: next_st.rdata = {23'h00_0000, apb_if.valid,
                                        apb_if.data};
        default: begin // Unmapped read
          next_st.rdata = 32'h0000_0000;
          next_st.slverr = 1'b1;
        end
      endcase
    end else if (psel & ~penable & pwrite) begin // Decode write address
      next_st.slverr = !(paddr == UBD_OFF_CTRL || paddr == UBD_OFF_BOS ||
                         paddr == UBD_OFF_EXT || paddr == UBD_OFF_RDSEL);
    end
    if (wr_phase) begin
      case (paddr)
        UBD_OFF_CTRL: begin
          // Clearing the load bit falls back to default content
          next_st.loaded = pwdata[0];
          if (!pwdata[0]) begin
            next_st.bos_total = UBD_BOS_TOTAL_RST; // see RULE6
            next_st.bos_ncaps = UBD_BOS_NCAPS_RST; // see RULE7
            next_st.ext_attr = UBD_EXT_ATTR_RST; // see RULE10
          end
        end
        UBD_OFF_BOS: begin
          next_st.bos_total = pwdata[15:0]; // see RULE6
          next_st.bos_ncaps = pwdata[23:16]; // see RULE7
        end
        // Reserved attribute bits never reach the host (see RULE11)
        UBD_OFF_EXT: next_st.ext_attr = pwdata & UBD_EXT_ATTR_MASK;
        UBD_OFF_RDSEL: begin
          next_st.rd_idx = pwdata[2:0];
          next_st.rd_sel = pwdata[4:3];
        end
        default: next_st.loaded = st.loaded;
      endcase
    end
    // Flag is recomputed each cycle from held content
    next_st.cfg_warn = ubd_attr_bad(next_st.ext_attr,
                                    nvm_link_power_mgmt_flag);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{loaded: 1'b0, bos_total: UBD_BOS_TOTAL_RST,
              bos_ncaps: UBD_BOS_NCAPS_RST, ext_attr: UBD_EXT_ATTR_RST,
              rdata: 32'h0000_0000, slverr: 1'b0, ready: 1'b0,
              rd_sel: 2'b00, rd_idx: 3'b000, rsp_data: 8'h00,
              rsp_valid: 1'b0, rsp_last: 1'b0, cfg_warn: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slverr & st.ready;
  assign rsp_data = st.rsp_data;
  assign rsp_valid = st.rsp_valid;
  assign rsp_last = st.rsp_last;

  // ****************************************
  // Checks
  // ****************************************
  // Every check samples on the bus clock and sleeps while reset is low.
  // A byte answer is looked at one edge after its request is taken, so
  // a request and its answer never share a cycle in these properties.

  // Companion descriptor: every byte is a fixed value
  epc_len_a: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd0 |=>
    rsp_valid && rsp_data == 8'h06 && !rsp_last)
    else $error("companion length byte wrong");

  epc_header_a: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd1 |=>
    rsp_valid && rsp_data == 8'h30)
    else $error("companion type byte wrong");

  epc_burst_a: assert property ( // see RULE2
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd2 |=>
    rsp_data == 8'h00 && rsp_data <= UBD_EPC_BURST_MAX)
    else $error("companion burst not zero");

  epc_attr_a: assert property ( // see RULE3
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd3 |=>
    rsp_data == 8'h00)
    else $error("companion attributes not zero");

  epc_bpi_a: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd4 |=>
    rsp_valid && rsp_data == 8'h04 && !rsp_last)
    else $error("bytes per interval low byte wrong");

  epc_bpi_hi_a: assert property ( // see RULE4
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd5 |=>
    rsp_valid && rsp_data == 8'h00 && rsp_last)
    else $error("bytes per interval high byte wrong");

  // A loaded image must not move the companion bytes-per-interval low byte
  epc_fixed_a: assert property ( // see RULE5
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx == 3'd4 &&
    st.loaded |=> rsp_data == 8'h04)
    else $error("companion depends on loaded data");

  epc_size_a: assert property ( // see RULE1
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EPC && req_idx > 3'd5 |=>
    !rsp_valid)
    else $error("companion longer than six bytes");

  // BOS header: fixed length and type, loaded total and count
  bos_header_a: assert property ( // see RULE8
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_BOS && req_idx == 3'd0 |=>
    rsp_data == 8'h05 && !rsp_last)
    else $error("BOS length not forced");

  bos_type_a: assert property ( // see RULE8
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_BOS && req_idx == 3'd1 |=>
    rsp_valid && rsp_data == 8'h0F)
    else $error("BOS type not forced");

  bos_count_a: assert property ( // see RULE7
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_BOS && req_idx == 3'd4 |=>
    rsp_valid && rsp_last && rsp_data == $past(st.bos_ncaps))
    else $error("capability count byte wrong");

  bos_total_a: assert property ( // see RULE6
    @(posedge pclk) disable iff (!presetn)
    wr_phase && paddr == UBD_OFF_CTRL && !pwdata[0] |=>
    st.bos_total == 16'h0016 && st.bos_ncaps == 8'h02)
    else $error("BOS defaults not restored");

  bos_load_a: assert property ( // see RULE7
    @(posedge pclk) disable iff (!presetn)
    wr_phase && paddr == UBD_OFF_BOS |=>
    st.bos_ncaps == $past(pwdata[23:16]))
    else $error("capability count not loaded");

  // Extension descriptor: fixed header, loaded attribute word
  ext_len_a: assert property ( // see RULE9
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EXT && req_idx == 3'd0 |=>
    rsp_valid && rsp_data == 8'h07)
    else $error("extension length wrong");

  ext_header_a: assert property ( // see RULE9
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EXT && req_idx == 3'd2 |=>
    rsp_data == 8'h02)
    else $error("extension capability type wrong");

  // Upper half of the attribute word is reserved and reads zero
  ext_resv_a: assert property ( // see RULE11
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EXT && req_idx == 3'd5 |=>
    rsp_valid && rsp_data == 8'h00 && !rsp_last)
    else $error("reserved attribute byte not zero");

  ext_last_a: assert property ( // see RULE15
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EXT && req_idx == 3'd6 |=>
    rsp_valid && rsp_last && rsp_data == 8'h00)
    else $error("extension last byte wrong");

  ext_attr_a: assert property ( // see RULE10
    @(posedge pclk) disable iff (!presetn)
    wr_phase && paddr == UBD_OFF_EXT |=>
    st.ext_attr[15:8] == $past(pwdata[15:8]) && st.ext_attr[0] == 1'b0)
    else $error("extension attributes not loaded");

  ext_default_a: assert property ( // see RULE10
    @(posedge pclk) disable iff (!presetn)
    wr_phase && paddr == UBD_OFF_CTRL && !pwdata[0] |=>
    st.ext_attr == 32'h0000_0006)
    else $error("extension default not restored");

  ext_order_a: assert property ( // see RULE15
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == UBD_SEL_EXT && req_idx == 3'd4 |=>
    rsp_data == st.ext_attr[15:8])
    else $error("BESL byte out of order");

  // Engine and bus handshakes
  fetch_refuse_a: assert property ( // Unused selector
    @(posedge pclk) disable iff (!presetn)
    req_valid && req_sel == 2'b10 |=>
    !rsp_valid)
    else $error("unused selector answered");

  apb_ready_a: assert property ( // No wait state
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=>
    pready)
    else $error("ready missing in access cycle");

  apb_pulse_a: assert property ( // Ready stands one cycle
    @(posedge pclk) disable iff (!presetn)
    pready |=>
    !pready)
    else $error("ready held too long");

endmodule : ubd_gen
`default_nettype wire

// *** dv/ubd_host_model.sv ***
// Far-side model: control engine fetching descriptor bytes
`timescale 1ns/10ps
`default_nettype none
module ubd_host_model (
  input wire logic pclk, // Clock
  input wire logic [7:0] rsp_data, // Byte answered
  input wire logic rsp_valid, // Answer strobe
  input wire logic rsp_last, // Final byte flag
  output logic [1:0] req_sel, // Descriptor choice
  output logic [2:0] req_idx, // Byte offset
  output logic req_valid // Request strobe
);
  // Idle lines start at a value no request uses first
  initial begin
    req_sel = 2'h2;
    req_idx = 3'h7;
    req_valid = 1'b0;
  end

  // One byte request; the answer stands one cycle after the take edge
  task automatic fetch(input logic [1:0] s, input logic [2:0] i,
                       output logic v, output logic l,
                       output logic [7:0] d);
    @(posedge pclk);
    req_sel <= s;
    req_idx <= i;
    req_valid <= 1'b1;
    @(posedge pclk);
    req_valid <= 1'b0;
    // Released lines show the inverse, so a stale copy cannot match
    req_sel <= ~s;
    req_idx <= ~i;
    // Answer is taken at the edge one cycle after the take edge
    @(posedge pclk);
    v = rsp_valid;
    l = rsp_last;
    d = rsp_data;
  endtask : fetch
endmodule : ubd_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the descriptor generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module tb_top;
  import ubd_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite; // Bus controls
  logic [11:0] paddr; // Byte address
  logic [31:0] pwdata, prdata, rdat; // Bus data
  logic pready, pslverr, rerr; // Bus answer
  logic nvm_link_power_mgmt_flag; // Memory LPM flag
  logic [1:0] req_sel; // Fetch choice
  logic [2:0] req_idx; // Fetch offset
  logic req_valid, rsp_valid, rsp_last; // Fetch strobes
  logic [7:0] rsp_data, cnt; // Answer byte, loaded count
  logic [15:0] tot; // Loaded total
  logic [31:0] att; // Loaded attributes
  int err_count, comparisons, seed; // Tallies and seed

  ubd_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_link_power_mgmt_flag(nvm_link_power_mgmt_flag),
    .req_sel(req_sel), .req_idx(req_idx), .req_valid(req_valid),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last));
  ubd_host_model u_host (.pclk(pclk), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .req_sel(req_sel),
    .req_idx(req_idx), .req_valid(req_valid));

  // Free-running 40 MHz clock
  always #12.5 pclk = ~pclk;

  // ****************************************
  // Tasks and models
  // ****************************************
  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // One APB transfer; only the watchdog ends a wait for ready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected {in range, last, byte}; fields packed low byte first
  function automatic logic [9:0] exp_b(input logic [1:0] s,
      input logic [2:0] i, input logic [15:0] t, input logic [7:0] n,
      input logic [31:0] a);
    logic [63:0] w;
    int sz;
    w = 64'h0;
    sz = 0;
    case (s)
      2'h0: begin
        w = 64'h0000_0004_0000_3006;
        sz = 6;
      end
      2'h1: begin
        w = {24'h00_0000, n, t, 16'h0F05};
        sz = 5;
      end
      2'h3: begin
        w = {8'h00, a, 24'h02_1007};
        sz = 7;
      end
      default: sz = 0; // Unused selector answers nothing
    endcase
    return {i < sz, i == sz - 1, w[{i, 3'h0} +: 8]};
  endfunction : exp_b

  // Walks every selector and offset, in range and beyond
  task automatic check_all(input logic [15:0] t, input logic [7:0] n,
                           input logic [31:0] a);
    logic v, l;
    logic [7:0] d;
    logic [9:0] e;
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 8; i++) begin
        e = exp_b(s[1:0], i[2:0], t, n, a);
        u_host.fetch(s[1:0], i[2:0], v, l, d);
        `CHK(v, e[9])
        if (e[9]) begin
          `CHK(d, e[7:0])
          `CHK(l, e[8])
        end
      end
    end
  endtask : check_all

  // Loader writes; the top byte of BOS stands for stored length junk
  task automatic load(input logic [15:0] t, input logic [7:0] n,
                      input logic [31:0] a);
    apb(1'b1, UBD_OFF_CTRL, 32'h0000_0001, rdat, rerr);
    apb(1'b1, UBD_OFF_BOS, {8'hA5, n, t}, rdat, rerr);
    apb(1'b1, UBD_OFF_EXT, a, rdat, rerr);
  endtask : load

  // Watchdog, far beyond the expected run of about a thousand cycles
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 68273;
    err_count = 0;
    comparisons = 0;
    pclk = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    nvm_link_power_mgmt_flag = 1'b1;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_all(16'h0016, 8'h02, 32'h0000_0006);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF, rdat, rerr);
    `CHK(rerr, 1'b1)
    apb(1'b0, 12'h018, 32'h0, rdat, rerr);
    `CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
    repeat (6) begin
      tot = $random(seed);
      cnt = $random(seed);
      att = $random(seed);
      att[1] = 1'b1;
      att[7:5] = 3'h0;
      att[0] = 1'b0;
      nvm_link_power_mgmt_flag <= att[1];
      load(tot, cnt, att);
      check_all(tot, cnt, att & 32'h0000_FF1E);
      apb(1'b1, UBD_OFF_RDSEL, 32'h0000_000A, rdat, rerr);
      apb(1'b0, UBD_OFF_RDDAT, 32'h0, rdat, rerr);
      `CHK(rdat[8:0], {1'b1, tot[7:0]})
      apb(1'b0, UBD_OFF_RDSEL, 32'h0, rdat, rerr);
      `CHK(rdat, 32'h0000_000A)
      apb(1'b0, UBD_OFF_CTRL, 32'h0, rdat, rerr);
      `CHK(rdat, 32'h0000_0001)
      apb(1'b0, UBD_OFF_BOS, 32'h0, rdat, rerr);
      `CHK(rdat, {8'h00, cnt, tot})
      apb(1'b0, UBD_OFF_STAT, 32'h0, rdat, rerr);
      `CHK(rdat[1:0], 2'h1)
    end
    // Faulty memory image: BESL without LPM, flag cleared
    nvm_link_power_mgmt_flag <= 1'b0;
    apb(1'b1, UBD_OFF_EXT, 32'h0000_0004, rdat, rerr);
    apb(1'b0, UBD_OFF_STAT, 32'h0, rdat, rerr);
    `CHK(rdat[1:0], 2'h2)
    // Reset in mid-run brings the defaults back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    nvm_link_power_mgmt_flag <= 1'b1;
    check_all(16'h0016, 8'h02, 32'h0000_0006);
    load(16'h1234, 8'h03, 32'h0000_F21E);
    apb(1'b1, UBD_OFF_CTRL, 32'h0, rdat, rerr);
    check_all(16'h0016, 8'h02, 32'h0000_0006);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
